// file: design/tra_pkg.sv
// Shared constants and carrier types for the TS rate adapter and alarm monitor
`default_nettype none
package tra_pkg;
	// Clock and link rates
	localparam int          CLK_KHZ      = 20000;
	localparam int          RATE_LO_KBPS = 19390;
	localparam int          RATE_HI_KBPS = 38780;
	localparam int          ACC_W        = 24;
	localparam logic [ACC_W-1:0] INC_LO  = ACC_W'((64'(RATE_LO_KBPS) << ACC_W) / (8 * CLK_KHZ));
	localparam logic [ACC_W-1:0] INC_HI  = ACC_W'((64'(RATE_HI_KBPS) << ACC_W) / (8 * CLK_KHZ));
	// Measurement window and PCR tick
	localparam int          WIN_US       = 1000;
	localparam int          WIN_CYC_DEF  = WIN_US * CLK_KHZ / 1000;
	localparam int          PCR_HZ       = 90000;
	localparam logic [7:0]  PCR_DIV      = 8'(CLK_KHZ * 1000 / PCR_HZ - 1);
	localparam logic [6:0]  PCT_PKTS     = 7'h63;
	// Packet layout
	localparam logic [7:0]  LEN_188      = 8'hBC;
	localparam logic [7:0]  LEN_204      = 8'hCC;
	localparam logic [7:0]  LEN_208      = 8'hD0;
	localparam logic [7:0]  SYNC_BYTE    = 8'h47;
	localparam logic [7:0]  NULL_PID_HI  = 8'h1F;
	localparam logic [7:0]  NULL_PID_LO  = 8'hFF;
	localparam logic [7:0]  NULL_HDR3    = 8'h10;
	localparam logic [7:0]  STUFF_BYTE   = 8'hFF;
	localparam logic [7:0]  DUMMY_BYTE   = 8'h00;
	localparam logic [7:0]  PCR_B0       = 8'h06;
	localparam logic [7:0]  PCR_B4       = 8'h0A;
	localparam int          AFC_BIT      = 5;
	localparam int          PCRF_BIT     = 4;
	// Register map
	localparam logic [7:0]  ADDR_CTRL    = 8'h00;
	localparam logic [7:0]  ADDR_AMASK   = 8'h04;
	localparam logic [7:0]  ADDR_GSEL    = 8'h08;
	localparam logic [7:0]  ADDR_GPOL    = 8'h0C;
	localparam logic [7:0]  ADDR_CMD     = 8'h10;
	localparam logic [7:0]  ADDR_STATUS  = 8'h14;
	localparam logic [7:0]  ADDR_IN_INFO = 8'h18;
	localparam logic [7:0]  ADDR_OUT_INFO = 8'h1C;
	localparam logic [7:0]  ADDR_REF_INFO = 8'h20;
	localparam logic [7:0]  ADDR_CNT0    = 8'h40;
	localparam logic [7:0]  ADDR_CNT7    = 8'h5C;
	// Control fields
	localparam int          CTRL_RATE_HI = 0;
	localparam int          CTRL_LEN_LSB = 1;
	localparam int          CTRL_RESTAMP = 3;
	localparam int          CTRL_LOCK    = 4;
	localparam int          CTRL_REF_HI  = 5;
	localparam logic [5:0]  CTRL_RST     = 6'h08;
	localparam logic [7:0]  AMASK_RST    = 8'hFF;
	// Alarm indices
	localparam int          AL_UNSUP     = 0;
	localparam int          AL_INVALID   = 1;
	localparam int          AL_OVERLAY   = 2;
	localparam int          AL_NO_ASI    = 3;
	localparam int          AL_NO_310    = 4;
	localparam int          AL_OVERFLOW  = 5;
	localparam int          AL_UNKNOWN   = 6;
	localparam int          AL_STARVE    = 7;
	localparam int          NUM_GPIO     = 8;
	localparam int          CNT_W        = 16;
	// Asynchronous pins from the card
	typedef struct packed {
		logic       overlay;   // display_overlay switch
		logic       not_asi;   // carrier present, not ASI
		logic       ref_byte;  // 310 input byte strobe
		logic [3:0] rear_id;   // rear module code
	} tra_pins_type;
	// Byte stream carrier
	typedef struct packed {
		logic [7:0] data;
		logic       sop;
		logic       valid;
	} tra_byte_type;
	typedef enum logic [0:0] {OS_IDLE = 1'b0, OS_SEND = 1'b1} tra_ostate_type;
endpackage : tra_pkg
`default_nettype wire

// file: design/tra_monitor.sv
// ASI to 310 rate adapter with alarm monitor and APB register file
// Overview of operation
// - Card OK unless an enabled alarm is active
// - Mask bit per alarm gates summary
// - Measure null packet percentage of output
// - Delete nulls to hold output rate
// - Null starvation is a major alarm
// - Overflow when payload packets get lost
// - Eight alarm outputs, idle level low at reset polarity
// - Count occurrences per assigned output
// - Counter reset command clears all counters
// - Output rate 19.39 or 38.78 Mbit/s
// - Output length 188/204/208, dummy padding
// - Optional PCR restamp for buffer delay
// - Clock free-running or locked to 310
// - Reference input rate setting 19.39/38.78
// - Flag missing or wrong-rate 310 input
// - Flag invalid and absent ASI input
// - Display overlay mode is an alarm
// - Report presence, size, rate of streams
// - Flag unknown and unsupported rear module
// - Per-output active level, default high
`default_nettype none
module tra_monitor
	import tra_pkg::*;
#(
	parameter int          WIN_CYC   = WIN_CYC_DEF, // Measurement window in cycles
	parameter logic [15:0] KNOWN_IDS = 16'h0003,    // Rear codes recognised
	parameter logic [15:0] FULL_IDS  = 16'h0001     // Rear codes with all jacks
) (
	input  wire logic         sys_clk,  // 20 MHz clock
	input  wire logic         nrst,     // Async reset, active low
	input  wire logic [7:0]   paddr,    // APB address
	input  wire logic         psel,     // APB select
	input  wire logic         penable,  // APB enable
	input  wire logic         pwrite,   // APB direction
	input  wire logic [31:0]  pwdata,   // APB write data
	output var  logic [31:0]  prdata,   // APB read data
	output var  logic         pready,   // APB ready
	output var  logic         pslverr,  // APB error
	input  wire tra_byte_type in_byte,  // ASI receiver bytes
	input  wire tra_pins_type pins,     // Asynchronous status pins
	output var  tra_byte_type out_byte, // 310 serializer bytes
	output var  logic [7:0]   gpio,     // Alarm outputs
	output var  logic         card_ok   // Summary status
);
	// Expected reference bytes per measurement window
	localparam int REF_EXP_LO = int'(64'(RATE_LO_KBPS) * WIN_CYC / (8 * CLK_KHZ));
	localparam int REF_EXP_HI = int'(64'(RATE_HI_KBPS) * WIN_CYC / (8 * CLK_KHZ));
	// Header byte positions of the packet identifier
	localparam logic [7:0] PID_HI_IDX = 8'h01;
	localparam logic [7:0] PID_LO_IDX = 8'h02;

	typedef struct packed {
		// Pin filter stages
		tra_pins_type s1, s2, s3, pst;
		logic                ref_prev;
		// Control registers
		logic [5:0]          ctrl;
		logic [7:0]          amask;
		logic [31:0]         gsel;
		logic [7:0]          gpol;
		// APB response
		logic [31:0]         prdata;
		logic                pready, pslverr;
		// Rate generator and packet banks
		logic [ACC_W-1:0]    acc;
		logic [0:1][0:187][7:0] mem;
		logic [1:0]          full;
		logic                wb, rb, wdrop;
		logic [7:0]          widx, in_len;
		logic [12:0]         pid;
		logic [0:1][7:0]     resid;
		logic [7:0]          pdiv;
		// Output sequencer
		tra_ostate_type      ost;
		logic                src_null, has_pcr;
		logic [7:0]          oidx, plen;
		logic [32:0]         pcr;
		tra_byte_type        out;
		// Rate measurement
		logic [23:0]         wcnt;
		logic [15:0]         in_cnt, in_rate, out_cnt, out_rate, ref_cnt, ref_rate;
		logic                asi_seen, ref_ok, drop_win, ovf;
		// Null share
		logic [6:0]          pkt_cnt, null_cnt, null_pct;
		// Alarm history and outputs
		logic [7:0]          al_prev;
		logic [0:7][CNT_W-1:0] cnt;
		logic [7:0]          gpio;
		logic                card_ok;
	} tra_state_type;

	tra_state_type st_reg, st_next;

	// Reset image of the whole state
	function automatic tra_state_type tra_reset_f();
		tra_state_type r;
		r = '0;
		r.ctrl = CTRL_RST;
		r.amask = AMASK_RST;
		return r;
	endfunction : tra_reset_f

	// Next state of the whole block
	always_comb begin
		tra_state_type q;
		logic        acc_c, slot, ref_edge, tick90, win_end, wr_ok, bus_sel;
		logic [7:0]  out_len, alarm, b, ridx;
		logic [ACC_W-1:0] inc;
		logic        clr_cnt, pkt_null, keep;
		int          sel;
		q = st_reg;
		acc_c = 1'b0;
		slot = 1'b0;
		b = DUMMY_BYTE;
		ridx = 8'h00;
		pkt_null = 1'b0;
		keep = 1'b0;
		sel = 0;
		// Defaults for the remaining locals
		ref_edge = 1'b0;
		tick90 = 1'b0;
		win_end = 1'b0;
		wr_ok = 1'b0;
		bus_sel = 1'b0;
		clr_cnt = 1'b0;
		out_len = LEN_188;
		alarm = 8'h00;
		inc = INC_LO;
		// Three-stage pin filter, value moves when stages two and three agree
		q.s1 = pins;
		q.s2 = st_reg.s1;
		q.s3 = st_reg.s2;
		q.pst = (~(st_reg.s2 ^ st_reg.s3) & st_reg.s3) | ((st_reg.s2 ^ st_reg.s3) & st_reg.pst);
		q.ref_prev = st_reg.pst.ref_byte;
		ref_edge = st_reg.pst.ref_byte & ~st_reg.ref_prev;
		// Byte slot from on-board NCO or from 310 input bytes
		inc = st_reg.ctrl[CTRL_RATE_HI] ? INC_HI : INC_LO;
		{acc_c, q.acc} = {1'b0, st_reg.acc} + {1'b0, inc};
		slot = st_reg.ctrl[CTRL_LOCK] ? ref_edge : acc_c;
		// Output length selection
		case (st_reg.ctrl[CTRL_LEN_LSB +: 2])
			2'h1: out_len = LEN_204;
			2'h2: out_len = LEN_208;
			default: out_len = LEN_188;
		endcase
		// PCR time base in 90 kHz ticks
		tick90 = (st_reg.pdiv == PCR_DIV);
		q.pdiv = tick90 ? 8'h00 : st_reg.pdiv + 8'h01;
		for (int k = 0; k < 2; k++) begin
			if (tick90 && st_reg.full[k] && st_reg.resid[k] != 8'hFF)
				q.resid[k] = st_reg.resid[k] + 8'h01;
		end
		// Input packet capture into two banks
		q.drop_win = st_reg.drop_win;
		if (in_byte.valid) begin
			q.in_cnt = (st_reg.in_cnt == 16'hFFFF) ? st_reg.in_cnt : st_reg.in_cnt + 16'h0001;
			if (in_byte.sop) begin
				if (st_reg.widx != 8'h00)
					q.in_len = st_reg.widx;
				q.widx = 8'h01;
				q.wdrop = st_reg.full[st_reg.wb];
			end else if (st_reg.widx != 8'hFF) begin
				q.widx = st_reg.widx + 8'h01;
			end
			ridx = in_byte.sop ? 8'h00 : st_reg.widx;
			if (!q.wdrop && ridx < LEN_188)
				q.mem[st_reg.wb][ridx] = in_byte.data;
			// Identifier kept even for a dropped packet
			if (ridx == PID_HI_IDX)
				q.pid[12:8] = in_byte.data[4:0];
			if (ridx == PID_LO_IDX)
				q.pid[7:0] = in_byte.data;
			if (ridx == LEN_188 - 8'h01) begin
				pkt_null = (st_reg.pid == {NULL_PID_HI[4:0], NULL_PID_LO});
				if (st_reg.wdrop) begin
					if (!pkt_null)
						q.drop_win = 1'b1;
				end else begin
					// Nulls are deleted while a packet is already waiting
					keep = !(pkt_null && st_reg.full[~st_reg.wb]);
					if (keep) begin
						q.full[st_reg.wb] = 1'b1;
						q.resid[st_reg.wb] = 8'h00;
						q.wb = ~st_reg.wb;
					end
				end
			end
		end
		// Output sequencer
		q.out.valid = 1'b0;
		q.out.sop = 1'b0;
		case (st_reg.ost)
			OS_IDLE: begin
				// Pick the waiting bank or a null packet
				q.src_null = !st_reg.full[st_reg.rb];
				q.has_pcr = st_reg.mem[st_reg.rb][3][AFC_BIT]
					&& st_reg.mem[st_reg.rb][4] != 8'h00
					&& st_reg.mem[st_reg.rb][5][PCRF_BIT];
				q.pcr = {st_reg.mem[st_reg.rb][6], st_reg.mem[st_reg.rb][7],
					st_reg.mem[st_reg.rb][8], st_reg.mem[st_reg.rb][9],
					st_reg.mem[st_reg.rb][10][7]}
					+ {25'h0, st_reg.resid[st_reg.rb]};
				q.oidx = 8'h00;
				q.plen = out_len;
				q.ost = OS_SEND;
				pkt_null = q.src_null
					|| ((st_reg.mem[st_reg.rb][1][4:0] == NULL_PID_HI[4:0])
					&& (st_reg.mem[st_reg.rb][2] == NULL_PID_LO));
				// Null share over each run of one hundred packets
				q.null_cnt = st_reg.null_cnt + {6'h00, pkt_null};
				q.pkt_cnt = st_reg.pkt_cnt + 7'h01;
				if (st_reg.pkt_cnt == PCT_PKTS) begin
					q.null_pct = q.null_cnt;
					q.null_cnt = 7'h00;
					q.pkt_cnt = 7'h00;
				end
			end
			OS_SEND: begin
				ridx = (st_reg.oidx < LEN_188) ? st_reg.oidx : 8'h00;
				// Null packet image
				if (st_reg.src_null) begin
					case (st_reg.oidx)
						8'h00: b = SYNC_BYTE;
						8'h01: b = NULL_PID_HI;
						8'h02: b = NULL_PID_LO;
						8'h03: b = NULL_HDR3;
						default: b = (st_reg.oidx < LEN_188) ? STUFF_BYTE : DUMMY_BYTE;
					endcase
				end else if (st_reg.oidx < LEN_188) begin
					// Stored packet, PCR bytes optionally replaced
					b = st_reg.mem[st_reg.rb][ridx];
					if (st_reg.ctrl[CTRL_RESTAMP] && st_reg.has_pcr
						&& st_reg.oidx >= PCR_B0 && st_reg.oidx <= PCR_B4) begin
						case (st_reg.oidx - PCR_B0)
							8'h00: b = st_reg.pcr[32:25];
							8'h01: b = st_reg.pcr[24:17];
							8'h02: b = st_reg.pcr[16:9];
							8'h03: b = st_reg.pcr[8:1];
							default: b = {st_reg.pcr[0], b[6:0]};
						endcase
					end
				end else begin
					b = DUMMY_BYTE;
				end
				// Byte handed to the serializer on a slot
				if (slot) begin
					q.out.valid = 1'b1;
					q.out.sop = (st_reg.oidx == 8'h00);
					q.out.data = b;
					q.out_cnt = (st_reg.out_cnt == 16'hFFFF) ? st_reg.out_cnt
						: st_reg.out_cnt + 16'h0001;
					q.oidx = st_reg.oidx + 8'h01;
					if (st_reg.oidx == st_reg.plen - 8'h01) begin
						q.ost = OS_IDLE;
						if (!st_reg.src_null) begin
							q.full[st_reg.rb] = 1'b0;
							q.rb = ~st_reg.rb;
						end
					end
				end
			end
			default: q.ost = OS_IDLE;
		endcase
		// Rate window for input, output and 310 reference
		if (ref_edge)
			q.ref_cnt = (st_reg.ref_cnt == 16'hFFFF) ? st_reg.ref_cnt : st_reg.ref_cnt + 16'h0001;
		win_end = (st_reg.wcnt == 24'(WIN_CYC - 1));
		q.wcnt = win_end ? 24'h0 : st_reg.wcnt + 24'h1;
		if (win_end) begin
			q.in_rate = st_reg.in_cnt;
			q.out_rate = st_reg.out_cnt;
			q.ref_rate = st_reg.ref_cnt;
			q.asi_seen = (st_reg.in_cnt != 16'h0000);
			// Reference must sit within 1/16 of the configured byte rate
			if (st_reg.ctrl[CTRL_REF_HI])
				q.ref_ok = 32'(st_reg.ref_cnt) >= 32'(REF_EXP_HI - REF_EXP_HI / 16)
					&& 32'(st_reg.ref_cnt) <= 32'(REF_EXP_HI + REF_EXP_HI / 16);
			else
				q.ref_ok = 32'(st_reg.ref_cnt) >= 32'(REF_EXP_LO - REF_EXP_LO / 16)
					&& 32'(st_reg.ref_cnt) <= 32'(REF_EXP_LO + REF_EXP_LO / 16);
			q.ovf = q.drop_win;
			q.drop_win = 1'b0;
			q.in_cnt = {15'h0, in_byte.valid};
			q.out_cnt = {15'h0, q.out.valid};
			q.ref_cnt = {15'h0, ref_edge};
		end
		// Alarm conditions
		alarm[AL_UNSUP] = KNOWN_IDS[st_reg.pst.rear_id] && !FULL_IDS[st_reg.pst.rear_id];
		alarm[AL_UNKNOWN] = !KNOWN_IDS[st_reg.pst.rear_id];
		alarm[AL_INVALID] = st_reg.pst.not_asi;
		alarm[AL_NO_ASI] = !st_reg.asi_seen && !st_reg.pst.not_asi;
		alarm[AL_OVERLAY] = st_reg.pst.overlay;
		alarm[AL_NO_310] = !st_reg.ref_ok;
		alarm[AL_OVERFLOW] = st_reg.ovf;
		alarm[AL_STARVE] = st_reg.asi_seen && st_reg.null_pct == 7'h00;
		// Alarm image kept for edges and status
		q.al_prev = alarm;
		// Summary of the enabled alarms
		q.card_ok = ~|(alarm & st_reg.amask);
		// APB slave, ready one cycle after setup
		bus_sel = psel && !penable;
		wr_ok = psel && penable && st_reg.pready && pwrite;
		q.pready = bus_sel;
		clr_cnt = wr_ok && paddr == ADDR_CMD && pwdata[0];
		// Error flag stands only with its ready pulse
		q.pslverr = 1'b0;
		if (bus_sel) begin
			q.prdata = 32'h0;
			case (paddr)
				ADDR_CTRL: q.prdata = {26'h0, st_reg.ctrl};
				ADDR_AMASK: q.prdata = {24'h0, st_reg.amask};
				ADDR_GSEL: q.prdata = st_reg.gsel;
				ADDR_GPOL: q.prdata = {24'h0, st_reg.gpol};
				ADDR_CMD: q.prdata = 32'h0;
				ADDR_STATUS: q.prdata = {16'h0, st_reg.null_pct, st_reg.card_ok, st_reg.al_prev};
				ADDR_IN_INFO: q.prdata = {7'h0, st_reg.asi_seen, st_reg.in_len, st_reg.in_rate};
				ADDR_OUT_INFO: q.prdata = {7'h0, 1'b1, out_len, st_reg.out_rate};
				ADDR_REF_INFO: q.prdata = {15'h0, st_reg.ref_ok, st_reg.ref_rate};
				default: begin
					if (paddr >= ADDR_CNT0 && paddr <= ADDR_CNT7 && paddr[1:0] == 2'b00)
						q.prdata = {16'h0, st_reg.cnt[paddr[4:2]]};
					else
						q.pslverr = 1'b1;
				end
			endcase
		end
		// Register writes in the access cycle
		if (wr_ok) begin
			case (paddr)
				ADDR_CTRL: q.ctrl = pwdata[5:0];
				ADDR_AMASK: q.amask = pwdata[7:0];
				ADDR_GSEL: q.gsel = pwdata;
				ADDR_GPOL: q.gpol = pwdata[7:0];
				default: ;
			endcase
		end
		// Alarm outputs and occurrence counters, a new event wins over clear
		for (int g = 0; g < NUM_GPIO; g++) begin
			sel = int'(st_reg.gsel[4*g +: 3]);
			q.gpio[g] = (st_reg.gsel[4*g+3] && alarm[sel]) ^ st_reg.gpol[g];
			// Clear first, so an event in the same cycle still counts
			if (clr_cnt)
				q.cnt[g] = '0;
			if (st_reg.gsel[4*g+3] && alarm[sel] && !st_reg.al_prev[sel])
				q.cnt[g] = (q.cnt[g] == {CNT_W{1'b1}}) ? q.cnt[g] : q.cnt[g] + 16'h0001;
		end
		st_next = q;
	end

	// State register
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st_reg <= tra_reset_f();
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from state flip-flops
	assign prdata   = st_reg.prdata;
	assign pready   = st_reg.pready;
	assign pslverr  = st_reg.pslverr;
	assign out_byte = st_reg.out;
	assign gpio     = st_reg.gpio;
	assign card_ok  = st_reg.card_ok;
endmodule : tra_monitor
`default_nettype wire

// file: tb/tra_check_monitor.sv
// Port-level assertions for the rate adapter, bound to its top module
`default_nettype none
module tra_check
	import tra_pkg::*;
(
	input wire logic         sys_clk,  // Clock
	input wire logic         nrst,     // Reset, active low
	input wire logic         psel,     // APB select
	input wire logic         penable,  // APB enable
	input wire logic         pready,   // APB ready
	input wire logic         pslverr,  // APB error
	input wire tra_byte_type out_byte  // 310 bytes
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	logic [8:0] len_reg;
	logic       seen_reg;
	// Byte index within the current output packet
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			len_reg  <= 9'h000;
			seen_reg <= 1'b0;
		end else if (out_byte.valid) begin
			len_reg  <= out_byte.sop ? 9'h001 : len_reg + 9'h001;
			seen_reg <= seen_reg | out_byte.sop;
		end
	end
	a_ready_follows: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_ready_access: assert property (pready |-> psel && penable)
		else $error("pready outside access phase");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_byte_pulse: assert property (out_byte.valid |=> !out_byte.valid)
		else $error("output byte strobe too long");
	a_sop_sync: assert property (out_byte.valid && out_byte.sop |-> out_byte.data == SYNC_BYTE)
		else $error("packet start without sync byte");
	a_pkt_len: assert property (out_byte.valid && out_byte.sop && seen_reg
		|-> len_reg inside {9'd188, 9'd204, 9'd208})
		else $error("output packet length wrong");
	a_pad_zero: assert property (out_byte.valid && !out_byte.sop && seen_reg && len_reg >= 9'd188
		|-> out_byte.data == DUMMY_BYTE)
		else $error("padding byte not zero");
endmodule : tra_check
bind tra_monitor tra_check chk_u (.sys_clk(sys_clk), .nrst(nrst), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr), .out_byte(out_byte));
`default_nettype wire

// file: tb/tra_asi_src.sv
// Transport stream source and 310 reference strobe model
`default_nettype none
module tra_asi_src
	import tra_pkg::*;
(
	input  wire logic         sys_clk,  // Clock
	input  wire logic         nrst,     // Reset, active low
	input  wire logic         on,       // Send packets
	input  wire logic         nul,      // Send null packets
	input  wire logic [3:0]   gap,      // Cycles per byte
	input  wire logic [3:0]   ref_half, // Strobe half period, 0 stops
	output var  tra_byte_type asi,      // Bytes to the adapter
	output var  logic         ref_byte  // 310 reference strobe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] idx;
	logic [7:0] dat;
	logic [3:0] tick;
	logic [3:0] rt;
	// Header bytes, null packets carry the reserved identifier
	always_comb begin
		case (idx)
			8'h00: dat = SYNC_BYTE;
			8'h01: dat = nul ? NULL_PID_HI : 8'h01;
			8'h02: dat = nul ? NULL_PID_LO : 8'h00;
			8'h03: dat = NULL_HDR3;
			default: dat = idx;
		endcase
	end
	// Byte pacing, idle data keeps changing
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			idx  <= 8'h00;
			tick <= 4'h0;
			asi  <= '0;
		end else begin
			asi.valid <= 1'b0;
			asi.sop   <= 1'b0;
			asi.data  <= ~asi.data;
			tick      <= (tick >= gap - 4'h1) ? 4'h0 : tick + 4'h1;
			if (on && tick == 4'h0) begin
				asi.valid <= 1'b1;
				asi.sop   <= idx == 8'h00;
				asi.data  <= dat;
				idx       <= (idx == 8'hBB) ? 8'h00 : idx + 8'h01;
			end
		end
	end
	// Reference strobe stands still when stopped
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rt       <= 4'h0;
			ref_byte <= 1'b0;
		end else if (ref_half == 4'h0) begin
			ref_byte <= 1'b0;
		end else if (rt >= ref_half - 4'h1) begin
			rt       <= 4'h0;
			ref_byte <= ~ref_byte;
		end else begin
			rt <= rt + 4'h1;
		end
	end
endmodule : tra_asi_src
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the rate adapter and alarm monitor
`default_nettype none
module testbench
	import tra_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic         sys_clk, nrst, psel, penable, pwrite, pready, pslverr, er;
	logic         on, nul, ov, na, ref_b, card_ok;
	logic [7:0]   paddr, gpio;
	logic [31:0]  pwdata, prdata, rd;
	logic [3:0]   gap, ref_half, rid;
	tra_byte_type in_byte, out_byte;
	int           failures, comparisons;
	tra_monitor #(.WIN_CYC(400)) dut_u (.sys_clk(sys_clk), .nrst(nrst), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .in_byte(in_byte), .pins({ov, na, ref_b, rid}),
		.out_byte(out_byte), .gpio(gpio), .card_ok(card_ok));
	tra_asi_src src_u (.sys_clk(sys_clk), .nrst(nrst), .on(on), .nul(nul), .gap(gap),
		.ref_half(ref_half), .asi(in_byte), .ref_byte(ref_b));
	// Clock
	always #25 sys_clk = ~sys_clk;
	task chk(input string n, input logic [31:0] s, e);
		comparisons++;
		if (s !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task stop_test;
		if (failures == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : stop_test
	task wt(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : wt
	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge sys_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do
			@(posedge sys_clk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		chk("pready", 32'(pready), 32'h1);
	endtask : apb
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask : wr
	task rdc(input string n, input logic [7:0] a, input logic [31:0] e, m);
		apb(a, 1'b0, 32'h0);
		chk(n, rd & m, e);
	endtask : rdc
	task rng(input string n, input int lo, hi);
		apb(ADDR_OUT_INFO, 1'b0, 32'h0);
		chk(n, 32'(rd[15:0] >= lo && rd[15:0] <= hi), 32'h1);
	endtask : rng
	task t_regs;
		rdc("ctrl", ADDR_CTRL, 32'h8, 32'hFFFFFFFF);
		rdc("amask", ADDR_AMASK, 32'hFF, 32'hFFFFFFFF);
		rdc("gsel", ADDR_GSEL, 32'h0, 32'hFFFFFFFF);
		rdc("gpol", ADDR_GPOL, 32'h0, 32'hFFFFFFFF);
		rdc("unmapped", 8'h30, 32'h0, 32'hFFFFFFFF);
		chk("slverr", 32'(er), 32'h1);
		chk("card_ok", 32'(card_ok), 32'h0);
		rdc("alarms", ADDR_STATUS, 32'h18, 32'h7F);
	endtask : t_regs
	task t_mask;
		wr(ADDR_AMASK, 32'h4);
		wt(8);
		chk("ok_masked", 32'(card_ok), 32'h1);
		ov <= 1'b1;
		wt(8);
		chk("ok_overlay", 32'(card_ok), 32'h0);
		rdc("overlay", ADDR_STATUS, 32'h4, 32'h104);
		ov <= 1'b0;
		wt(8);
		chk("ok_back", 32'(card_ok), 32'h1);
	endtask : t_mask
	task t_gpio;
		wr(ADDR_GSEL, 32'hBA);
		wr(ADDR_CMD, 32'h1);
		wt(4);
		chk("gpio", 32'(gpio), 32'h2);
		repeat (3) begin
			ov <= 1'b1;
			wt(8);
			ov <= 1'b0;
			wt(8);
		end
		rdc("count", ADDR_CNT0, 32'h3, 32'hFFFF);
		wr(ADDR_GPOL, 32'hFE);
		ov <= 1'b1;
		wt(8);
		chk("gpio_pol", 32'(gpio), 32'hFD);
		ov <= 1'b0;
		wr(ADDR_CMD, 32'h1);
		rdc("cleared", ADDR_CNT0, 32'h0, 32'hFFFF);
		wr(ADDR_GPOL, 32'h0);
	endtask : t_gpio
	task t_rear;
		rid <= 4'h1;
		wt(8);
		rdc("unsup", ADDR_STATUS, 32'h1, 32'h43);
		rid <= 4'h5;
		na  <= 1'b1;
		wt(8);
		rdc("unknown", ADDR_STATUS, 32'h42, 32'h43);
		rid <= 4'h0;
		na  <= 1'b0;
	endtask : t_rear
	task t_stream;
		on <= 1'b1;
		wt(1200);
		rdc("overflow", ADDR_STATUS, 32'hA0, 32'hAA);
		nul <= 1'b1;
		wt(1200);
		rdc("null_del", ADDR_STATUS, 32'h0, 32'h2A);
		rdc("in_info", ADDR_IN_INFO, 32'h1BC0000, 32'h1FF0000);
	endtask : t_stream
	task t_len;
		int lens[3];
		int n;
		int k;
		lens = '{188, 204, 208};
		for (int i = 0; i < 3; i++) begin
			wr(ADDR_CTRL, 32'h8 | 32'(i << 1));
			n = 0;
			k = 0;
			repeat (9000) begin
				@(posedge sys_clk);
				if (out_byte.valid === 1'b1) begin
					if (out_byte.sop === 1'b1) k++;
					if (k == 3) break;
					if (k == 2) n++;
				end
			end
			chk("pkt_len", 32'(n), 32'(lens[i]));
		end
	endtask : t_len
	task t_rate;
		wr(ADDR_CTRL, 32'h8);
		wt(900);
		rng("rate_lo", 47, 50);
		wr(ADDR_CTRL, 32'h9);
		wt(900);
		rng("rate_hi", 95, 98);
		ref_half <= 4'h4;
		wr(ADDR_CTRL, 32'h8);
		wt(900);
		rdc("ref_ok", ADDR_STATUS, 32'h0, 32'h10);
		wr(ADDR_CTRL, 32'h28);
		wt(900);
		rdc("ref_bad", ADDR_STATUS, 32'h10, 32'h10);
		ref_half <= 4'h3;
		wr(ADDR_CTRL, 32'h18);
		wt(900);
		rng("locked", 65, 68);
	endtask : t_rate
	// Watchdog
	initial begin
		repeat (60000) @(posedge sys_clk);
		failures++;
		stop_test();
	end
	// Main sequence
	initial begin
		sys_clk = 1'b0;
		nrst = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{on, nul, ov, na, ref_half, rid} = '0;
		gap = 4'h1;
		failures = 0;
		comparisons = 0;
		repeat (8) @(posedge sys_clk);
		nrst <= 1'b1;
		t_regs();
		t_mask();
		t_gpio();
		t_rear();
		t_stream();
		t_len();
		t_rate();
		stop_test();
	end
endmodule : testbench
`default_nettype wire
